// [iocmd_core.sv]
`timescale 1ns/100ps
// Summary of operation
// - direction readback: hex, one bit per line
// - single-line direction answers I or O
// - single-line read returns present level 1/0
// - nonexistent line gives VALUE ERROR reply
// - decimal position equals hex bit addressing
// - mode readback returns one letter C/D/E/I/T
// - timer readback as signed 5.2 seconds
// - input address readback as two hex
// - analog poll always answers fixed value
// - analog poll restarts output watchdog timeout
// - address-only frame is treated as poll
// - tally readback is seven zero-padded digits
// - tally saturates at maximum until cleared
// - tally cleared by take or clear command
// - tally is zero after power-up
// - remote reset keeps outputs and tally
// - remote reset needs preceding write enable
// - note readback returns stored user message
// - boot output readback as hex digits
// - config readback gives eight hex characters
// - watchdog readback as signed minutes value
// - error reply: ?, address, space, text
// - protected command without enable is refused
module iocmd_core #(
	parameter int NLINES = 64
) (
	input wire logic CLK,
	input wire logic SRST,
	input wire iocmd_pkg::apb_req_t APB_REQ,
	output iocmd_pkg::apb_rsp_t APB_RSP,
	input wire logic [7:0] RX_DATA,
	input wire logic RX_VALID,
	output logic RX_READY,
	output logic [7:0] TX_DATA,
	output logic TX_VALID,
	input wire logic TX_READY,
	input wire logic [NLINES-1:0] LINE_IN,
	input wire logic EVENT,
	output logic CPU_KICK,
	output logic DOG_KICK
);

	typedef struct packed {
		iocmd_pkg::st_t st;
		logic [iocmd_pkg::RX_MAX-1:0][7:0] rx;
		logic [4:0] rn;
		logic ovf;
		logic [31:0][7:0] tb;
		logic [5:0] tn;
		logic [5:0] tp;
		logic wren;
		logic [27:0] tally;
		logic [63:0] dir;
		logic [63:0] boot;
		logic [31:0] cfg;
		logic [2:0] mode;
		logic [31:0] ctmr;
		logic [31:0] dtime;
		logic [7:0] iaddr;
		logic [15:0][7:0] note;
		iocmd_pkg::apb_rsp_t rsp;
		logic rx_rdy;
		logic [7:0] txd;
		logic txv;
		logic kick;
		logic dog;
	} state_t;

	state_t st_ff;
	state_t nxt_st;

	// ----------------------------------------------------------------
	// character helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] hexch(input logic [3:0] v);
		return (v < 4'ha) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
	endfunction

	// returns {bad, value}
	function automatic logic [4:0] hexval(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) begin
			return {1'b0, 4'(c - 8'h30)};
		end
		if (c >= 8'h41 && c <= 8'h46) begin
			return {1'b0, 4'(c - 8'h37)};
		end
		return 5'h10;
	endfunction

	function automatic logic [4:0] decval(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) begin
			return {1'b0, 4'(c - 8'h30)};
		end
		return 5'h10;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		state_t n;
		logic [63:0] lines;
		logic [63:0] hexsrc;
		logic [31:0] fixsrc;
		logic [119:0] msg;
		logic [27:0] inc;
		logic cy;
		logic hashp;
		logic [4:0] blen;
		logic [3:0] words;
		logic [6:0] nl;
		logic [4:0] nd;
		logic [4:0] hv;
		logic [4:0] lv;
		logic decp;
		logic [6:0] idx;
		iocmd_pkg::cmd_t cmd;
		iocmd_pkg::err_t err;
		logic [7:0] ck;
		integer p;
		integer i;
		n = st_ff;
		lines = 64'(LINE_IN);
		hexsrc = '0;
		fixsrc = '0;
		msg = '0;
		inc = '0;
		cy = 1'b1;
		hashp = 1'b0;
		blen = '0;
		words = '0;
		nl = '0;
		nd = '0;
		hv = '0;
		lv = '0;
		decp = 1'b0;
		idx = '0;
		cmd = iocmd_pkg::K_NONE;
		err = iocmd_pkg::E_NONE;
		ck = '0;
		p = 0;
		i = 0;
		n.kick = 1'b0;
		n.dog = 1'b0;

		// saturating decimal event counter
		for (i = 0; i < 7; i++) begin
			inc[i*4 +: 4] = (cy && st_ff.tally[i*4 +: 4] == 4'h9) ? 4'h0 :
				st_ff.tally[i*4 +: 4] + {3'h0, cy};
			cy = cy && st_ff.tally[i*4 +: 4] == 4'h9;
		end
		if (EVENT && st_ff.tally != iocmd_pkg::TALLY_MAX) begin
			n.tally = inc;
		end

		// ------------------------------------------------------------
		// apb slave: one wait state, registers stand in for eeprom
		// ------------------------------------------------------------
		n.rsp.pready = 1'b0;
		n.rsp.pslverr = 1'b0;
		if (APB_REQ.psel && APB_REQ.penable && !st_ff.rsp.pready) begin
			n.rsp.pready = 1'b1;
			n.rsp.prdata = '0;
			unique case (APB_REQ.paddr)
			iocmd_pkg::OFS_DIR_LO: n.rsp.prdata = st_ff.dir[31:0];
			iocmd_pkg::OFS_DIR_HI: n.rsp.prdata = st_ff.dir[63:32];
			iocmd_pkg::OFS_BOOT_LO: n.rsp.prdata = st_ff.boot[31:0];
			iocmd_pkg::OFS_BOOT_HI: n.rsp.prdata = st_ff.boot[63:32];
			iocmd_pkg::OFS_CONFIG: n.rsp.prdata = st_ff.cfg;
			iocmd_pkg::OFS_MODE: n.rsp.prdata = {29'h0, st_ff.mode};
			iocmd_pkg::OFS_CONT_TMR: n.rsp.prdata = st_ff.ctmr;
			iocmd_pkg::OFS_DOG_TIME: n.rsp.prdata = st_ff.dtime;
			iocmd_pkg::OFS_IN_ADDR: n.rsp.prdata = {24'h0, st_ff.iaddr};
			iocmd_pkg::OFS_TALLY: n.rsp.prdata = {4'h0, st_ff.tally};
			iocmd_pkg::OFS_STATUS:
				n.rsp.prdata = {30'h0, st_ff.st != iocmd_pkg::ST_RX,
					st_ff.wren};
			iocmd_pkg::OFS_LINE_LO: n.rsp.prdata = lines[31:0];
			iocmd_pkg::OFS_LINE_HI: n.rsp.prdata = lines[63:32];
			default: begin
				if (APB_REQ.paddr >= iocmd_pkg::OFS_NOTE0 &&
					APB_REQ.paddr <= iocmd_pkg::OFS_NOTE3 &&
					APB_REQ.paddr[1:0] == 2'h0) begin
					n.rsp.prdata = st_ff.note[4'((APB_REQ.paddr -
						iocmd_pkg::OFS_NOTE0) >> 2) * 4 +: 4];
				end else begin
					n.rsp.pslverr = 1'b1;
				end
			end
			endcase
			if (APB_REQ.pwrite) begin
				unique case (APB_REQ.paddr)
				iocmd_pkg::OFS_DIR_LO: n.dir[31:0] = APB_REQ.pwdata;
				iocmd_pkg::OFS_DIR_HI: n.dir[63:32] = APB_REQ.pwdata;
				iocmd_pkg::OFS_BOOT_LO: n.boot[31:0] = APB_REQ.pwdata;
				iocmd_pkg::OFS_BOOT_HI: n.boot[63:32] = APB_REQ.pwdata;
				iocmd_pkg::OFS_CONFIG: n.cfg = APB_REQ.pwdata;
				iocmd_pkg::OFS_MODE: n.mode = APB_REQ.pwdata[2:0];
				iocmd_pkg::OFS_CONT_TMR: n.ctmr = APB_REQ.pwdata;
				iocmd_pkg::OFS_DOG_TIME: n.dtime = APB_REQ.pwdata;
				iocmd_pkg::OFS_IN_ADDR: n.iaddr = APB_REQ.pwdata[7:0];
				default: begin
					if (!n.rsp.pslverr && APB_REQ.paddr >=
						iocmd_pkg::OFS_NOTE0 && APB_REQ.paddr <=
						iocmd_pkg::OFS_NOTE3) begin
						n.note[4'((APB_REQ.paddr -
							iocmd_pkg::OFS_NOTE0) >> 2) * 4 +: 4] =
							APB_REQ.pwdata;
					end
				end
				endcase
			end
		end

		// ------------------------------------------------------------
		// command frame handling
		// ------------------------------------------------------------
		case (st_ff.st)
		iocmd_pkg::ST_RX: begin
			if (RX_VALID) begin
				if (RX_DATA == iocmd_pkg::CH_DOLLAR ||
					RX_DATA == iocmd_pkg::CH_HASH) begin
					n.rx[0] = RX_DATA;
					n.rn = 5'h1;
					n.ovf = 1'b0;
				end else if (st_ff.rn != 5'h0) begin
					if (RX_DATA == iocmd_pkg::CH_CR) begin
						n.rn = 5'h0;
						if (st_ff.rn >= 5'h2 &&
							st_ff.rx[1] == st_ff.cfg[31:24]) begin
							n.rn = st_ff.rn;
							n.st = iocmd_pkg::ST_EXEC;
						end
					end else if (st_ff.rn < 5'(iocmd_pkg::RX_MAX)) begin
						n.rx[st_ff.rn] = RX_DATA;
						n.rn = st_ff.rn + 5'h1;
					end else begin
						n.ovf = 1'b1;
					end
				end
			end
		end
		iocmd_pkg::ST_EXEC: begin
			hashp = st_ff.rx[0] == iocmd_pkg::CH_HASH;
			blen = st_ff.rn - 5'h2;
			if (hashp) begin
				blen = (st_ff.rn >= 5'h4) ? st_ff.rn - 5'h4 : 5'h0;
			end
			words = (st_ff.cfg[3:0] == 4'h0) ? 4'h1 :
				(st_ff.cfg[3:0] > 4'h8) ? 4'h8 : st_ff.cfg[3:0];
			nl = {words, 3'h0};
			if (nl > 7'(NLINES)) begin
				nl = 7'(NLINES);
			end
			nd = {words, 1'b0};
			case (blen)
			5'h0: cmd = iocmd_pkg::K_POLL;
			5'h2: begin
				case ({st_ff.rx[2], st_ff.rx[3]})
				iocmd_pkg::TXT_DIR_ALL: cmd = iocmd_pkg::K_DIR_ALL;
				iocmd_pkg::TXT_POLL: cmd = iocmd_pkg::K_POLL;
				iocmd_pkg::TXT_TALLY: cmd = iocmd_pkg::K_TALLY;
				iocmd_pkg::TXT_TALLY_TAKE: cmd = iocmd_pkg::K_TALLY_TAKE;
				iocmd_pkg::TXT_TALLY_CLR: cmd = iocmd_pkg::K_TALLY_CLR;
				iocmd_pkg::TXT_CONFIG_ALT: cmd = iocmd_pkg::K_CONFIG_ALT;
				iocmd_pkg::TXT_CPU_KICK: cmd = iocmd_pkg::K_CPU_KICK;
				iocmd_pkg::TXT_WREN: cmd = iocmd_pkg::K_WREN;
				default: cmd = iocmd_pkg::K_NONE;
				endcase
			end
			5'h3: begin
				case ({st_ff.rx[2], st_ff.rx[3], st_ff.rx[4]})
				iocmd_pkg::TXT_CONT_MODE: cmd = iocmd_pkg::K_CONT_MODE;
				iocmd_pkg::TXT_CONT_TMR: cmd = iocmd_pkg::K_CONT_TMR;
				iocmd_pkg::TXT_IN_ADDR: cmd = iocmd_pkg::K_IN_ADDR;
				iocmd_pkg::TXT_USER_NOTE: cmd = iocmd_pkg::K_USER_NOTE;
				iocmd_pkg::TXT_BOOT_OUT: cmd = iocmd_pkg::K_BOOT_OUT;
				iocmd_pkg::TXT_CONFIG: cmd = iocmd_pkg::K_CONFIG;
				iocmd_pkg::TXT_DOG_TIME: cmd = iocmd_pkg::K_DOG_TIME;
				default: cmd = iocmd_pkg::K_NONE;
				endcase
			end
			5'h4: begin
				case ({st_ff.rx[2], st_ff.rx[3]})
				iocmd_pkg::TXT_BIT_LVL: cmd = iocmd_pkg::K_BIT_LVL;
				iocmd_pkg::TXT_POS_LVL: cmd = iocmd_pkg::K_POS_LVL;
				default: cmd = iocmd_pkg::K_NONE;
				endcase
			end
			5'h5: begin
				case ({st_ff.rx[2], st_ff.rx[3], st_ff.rx[4]})
				iocmd_pkg::TXT_DIR_BIT: cmd = iocmd_pkg::K_DIR_BIT;
				iocmd_pkg::TXT_DIR_POS: cmd = iocmd_pkg::K_DIR_POS;
				iocmd_pkg::TXT_IN_BIT: cmd = iocmd_pkg::K_IN_BIT;
				iocmd_pkg::TXT_IN_POS: cmd = iocmd_pkg::K_IN_POS;
				default: cmd = iocmd_pkg::K_NONE;
				endcase
			end
			default: cmd = iocmd_pkg::K_NONE;
			endcase

			// line address: hex bit or decimal position
			decp = cmd == iocmd_pkg::K_DIR_POS ||
				cmd == iocmd_pkg::K_POS_LVL || cmd == iocmd_pkg::K_IN_POS;
			hv = decp ? decval(st_ff.rx[blen]) : hexval(st_ff.rx[blen]);
			lv = decp ? decval(st_ff.rx[blen + 5'h1]) :
				hexval(st_ff.rx[blen + 5'h1]);
			idx = decp ? 7'(hv[3:0]) * 7'h0a + 7'(lv[3:0]) :
				{hv[2:0], lv[3:0]};
			if (st_ff.ovf) begin
				err = iocmd_pkg::E_SYN;
			end else if (cmd == iocmd_pkg::K_NONE) begin
				err = iocmd_pkg::E_CMD;
			end else if (blen >= 5'h4 && (hv[4] || lv[4] ||
				(!decp && hv[3]) || idx >= nl)) begin
				err = iocmd_pkg::E_VALUE;
			end else if (cmd == iocmd_pkg::K_CPU_KICK && !st_ff.wren) begin
				err = iocmd_pkg::E_WP;
			end

			if (err != iocmd_pkg::E_NONE) begin
				case (err)
				iocmd_pkg::E_VALUE: msg = iocmd_pkg::MSG_VALUE;
				iocmd_pkg::E_WP: msg = iocmd_pkg::MSG_WP;
				iocmd_pkg::E_CMD: msg = iocmd_pkg::MSG_CMD;
				default: msg = iocmd_pkg::MSG_SYN;
				endcase
				n.tb[0] = iocmd_pkg::CH_QUERY;
				n.tb[1] = st_ff.cfg[31:24];
				n.tb[2] = iocmd_pkg::CH_SPACE;
				p = 3;
				for (i = 14; i >= 0; i--) begin
					if (msg[i*8 +: 8] != 8'h00) begin
						n.tb[p[4:0]] = msg[i*8 +: 8];
						p = p + 1;
					end
				end
				if (err == iocmd_pkg::E_WP) begin
					n.wren = 1'b0;
				end
			end else begin
				n.tb[0] = iocmd_pkg::CH_STAR;
				p = 1;
				if (hashp) begin
					for (i = 0; i < 23; i++) begin
						if (i <= int'(blen)) begin
							n.tb[p[4:0]] = st_ff.rx[i + 1];
							p = p + 1;
						end
					end
				end
				n.wren = cmd == iocmd_pkg::K_WREN;
				hexsrc = (cmd == iocmd_pkg::K_BOOT_OUT) ? st_ff.boot :
					(cmd == iocmd_pkg::K_CONFIG ||
					cmd == iocmd_pkg::K_CONFIG_ALT) ? {32'h0, st_ff.cfg} :
					(cmd == iocmd_pkg::K_IN_ADDR) ? {56'h0, st_ff.iaddr} :
					st_ff.dir;
				fixsrc = (cmd == iocmd_pkg::K_CONT_TMR) ? st_ff.ctmr :
					(cmd == iocmd_pkg::K_DOG_TIME) ? st_ff.dtime :
					(cmd == iocmd_pkg::K_POLL) ? iocmd_pkg::POLL_VALUE :
					{4'h0, st_ff.tally};
				case (cmd)
				iocmd_pkg::K_DIR_ALL, iocmd_pkg::K_BOOT_OUT,
				iocmd_pkg::K_CONFIG, iocmd_pkg::K_CONFIG_ALT,
				iocmd_pkg::K_IN_ADDR: begin
					if (cmd == iocmd_pkg::K_IN_ADDR) begin
						nd = 5'h2;
					end else if (cmd != iocmd_pkg::K_DIR_ALL &&
						cmd != iocmd_pkg::K_BOOT_OUT) begin
						nd = 5'h8;
					end
					for (i = 15; i >= 0; i--) begin
						if (i < int'(nd)) begin
							n.tb[p[4:0]] = hexch(hexsrc[i*4 +: 4]);
							p = p + 1;
						end
					end
				end
				iocmd_pkg::K_DIR_BIT, iocmd_pkg::K_DIR_POS: begin
					n.tb[p[4:0]] = st_ff.dir[idx[5:0]] ?
						iocmd_pkg::CH_OUT : iocmd_pkg::CH_IN;
					p = p + 1;
				end
				iocmd_pkg::K_BIT_LVL, iocmd_pkg::K_POS_LVL,
				iocmd_pkg::K_IN_BIT, iocmd_pkg::K_IN_POS: begin
					n.tb[p[4:0]] = iocmd_pkg::CH_ZERO |
						{7'h0, lines[idx[5:0]]};
					p = p + 1;
				end
				iocmd_pkg::K_CONT_MODE: begin
					case (iocmd_pkg::cmode_t'(st_ff.mode))
					iocmd_pkg::CM_CHANGE: n.tb[p[4:0]] = 8'h43;
					iocmd_pkg::CM_EDGE: n.tb[p[4:0]] = 8'h45;
					iocmd_pkg::CM_INPUT: n.tb[p[4:0]] = 8'h49;
					iocmd_pkg::CM_TIMER: n.tb[p[4:0]] = 8'h54;
					default: n.tb[p[4:0]] = 8'h44;
					endcase
					p = p + 1;
				end
				iocmd_pkg::K_CONT_TMR, iocmd_pkg::K_DOG_TIME,
				iocmd_pkg::K_POLL: begin
					n.tb[p[4:0]] = fixsrc[31] ? iocmd_pkg::CH_MINUS :
						iocmd_pkg::CH_PLUS;
					p = p + 1;
					for (i = 6; i >= 0; i--) begin
						if (i == 1) begin
							n.tb[p[4:0]] = iocmd_pkg::CH_DOT;
							p = p + 1;
						end
						n.tb[p[4:0]] = hexch(fixsrc[i*4 +: 4]);
						p = p + 1;
					end
					n.dog = cmd == iocmd_pkg::K_POLL;
				end
				iocmd_pkg::K_TALLY, iocmd_pkg::K_TALLY_TAKE: begin
					for (i = 6; i >= 0; i--) begin
						n.tb[p[4:0]] = hexch(st_ff.tally[i*4 +: 4]);
						p = p + 1;
					end
				end
				iocmd_pkg::K_USER_NOTE: begin
					for (i = 0; i < 16; i++) begin
						if (st_ff.note[i] != 8'h00) begin
							n.tb[p[4:0]] = st_ff.note[i];
							p = p + 1;
						end
					end
				end
				iocmd_pkg::K_CPU_KICK: n.kick = 1'b1;
				default: ;
				endcase
				// an event in the clearing cycle still counts
				if (cmd == iocmd_pkg::K_TALLY_TAKE ||
					cmd == iocmd_pkg::K_TALLY_CLR) begin
					n.tally = {27'h0, EVENT};
				end
				if (hashp) begin
					for (i = 0; i < 32; i++) begin
						if (i < p) begin
							ck = ck + n.tb[i];
						end
					end
					n.tb[p[4:0]] = hexch(ck[7:4]);
					n.tb[5'(p + 1)] = hexch(ck[3:0]);
					p = p + 2;
				end
			end
			n.tn = p[5:0];
			n.tp = 6'h0;
			n.rn = 5'h0;
			n.st = iocmd_pkg::ST_TX;
		end
		iocmd_pkg::ST_TX: begin
			if (!st_ff.txv || TX_READY) begin
				n.txv = 1'b0;
				if (st_ff.tp < st_ff.tn) begin
					n.txd = st_ff.tb[st_ff.tp[4:0]];
					n.txv = 1'b1;
					n.tp = st_ff.tp + 6'h1;
				end else begin
					n.st = iocmd_pkg::ST_RX;
				end
			end
		end
		default: n.st = iocmd_pkg::ST_RX;
		endcase
		n.rx_rdy = n.st == iocmd_pkg::ST_RX;
		nxt_st = n;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SRST) begin
			st_ff <= '0;
			st_ff.st <= iocmd_pkg::ST_RX;
			st_ff.tally <= '0;
			st_ff.cfg <= iocmd_pkg::RST_CONFIG;
			st_ff.mode <= 3'(iocmd_pkg::CM_DISABLED);
			st_ff.ctmr <= iocmd_pkg::RST_CONT_TMR;
			st_ff.dtime <= iocmd_pkg::RST_DOG_TIME;
			st_ff.iaddr <= iocmd_pkg::RST_IN_ADDR;
			st_ff.rx_rdy <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign APB_RSP = st_ff.rsp;
	assign RX_READY = st_ff.rx_rdy;
	assign TX_DATA = st_ff.txd;
	assign TX_VALID = st_ff.txv;
	assign CPU_KICK = st_ff.kick;
	assign DOG_KICK = st_ff.dog;

endmodule

// [iocmd_pkg.sv]
package iocmd_pkg;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ST_RX, ST_EXEC, ST_TX} st_t;
	typedef enum logic [2:0] {CM_CHANGE, CM_DISABLED, CM_EDGE, CM_INPUT,
		CM_TIMER} cmode_t;
	typedef enum logic [2:0] {E_NONE, E_VALUE, E_WP, E_CMD, E_SYN} err_t;
	typedef enum logic [4:0] {K_DIR_ALL, K_DIR_BIT, K_DIR_POS, K_BIT_LVL,
		K_POS_LVL, K_IN_BIT, K_IN_POS, K_CONT_MODE, K_CONT_TMR, K_IN_ADDR,
		K_POLL, K_TALLY, K_TALLY_TAKE, K_TALLY_CLR, K_USER_NOTE, K_BOOT_OUT,
		K_CONFIG, K_CONFIG_ALT, K_CPU_KICK, K_DOG_TIME, K_WREN,
		K_NONE} cmd_t;

	typedef struct packed {
		logic [7:0] paddr;
		logic pwrite;
		logic psel;
		logic penable;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_DIR_LO = 8'h00;
	localparam logic [7:0] OFS_DIR_HI = 8'h04;
	localparam logic [7:0] OFS_BOOT_LO = 8'h08;
	localparam logic [7:0] OFS_BOOT_HI = 8'h0c;
	localparam logic [7:0] OFS_CONFIG = 8'h10;
	localparam logic [7:0] OFS_MODE = 8'h14;
	localparam logic [7:0] OFS_CONT_TMR = 8'h18;
	localparam logic [7:0] OFS_DOG_TIME = 8'h1c;
	localparam logic [7:0] OFS_IN_ADDR = 8'h20;
	localparam logic [7:0] OFS_NOTE0 = 8'h24;
	localparam logic [7:0] OFS_NOTE3 = 8'h30;
	localparam logic [7:0] OFS_TALLY = 8'h34;
	localparam logic [7:0] OFS_STATUS = 8'h38;
	localparam logic [7:0] OFS_LINE_LO = 8'h3c;
	localparam logic [7:0] OFS_LINE_HI = 8'h40;

	// ----------------------------------------------------------------
	// reset values and fixed figures
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_CONFIG = 32'h3107_0102;
	localparam logic [31:0] RST_CONT_TMR = 32'h0000_0500;
	localparam logic [31:0] RST_DOG_TIME = 32'h0999_9999;
	localparam logic [7:0] RST_IN_ADDR = 8'h41;
	localparam logic [31:0] POLL_VALUE = 32'h0999_9999;
	localparam logic [27:0] TALLY_MAX = 28'h999_9999;
	localparam int RX_MAX = 24;

	// ----------------------------------------------------------------
	// characters and command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CH_STAR = 8'h2a;
	localparam logic [7:0] CH_QUERY = 8'h3f;
	localparam logic [7:0] CH_DOLLAR = 8'h24;
	localparam logic [7:0] CH_HASH = 8'h23;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_PLUS = 8'h2b;
	localparam logic [7:0] CH_MINUS = 8'h2d;
	localparam logic [7:0] CH_DOT = 8'h2e;
	localparam logic [7:0] CH_IN = 8'h49;
	localparam logic [7:0] CH_OUT = 8'h4f;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [15:0] TXT_DIR_ALL = 16'h5241;
	localparam logic [15:0] TXT_POLL = 16'h5244;
	localparam logic [15:0] TXT_TALLY = 16'h5245;
	localparam logic [15:0] TXT_TALLY_TAKE = 16'h4543;
	localparam logic [15:0] TXT_TALLY_CLR = 16'h4345;
	localparam logic [15:0] TXT_CONFIG_ALT = 16'h5253;
	localparam logic [15:0] TXT_CPU_KICK = 16'h5252;
	localparam logic [15:0] TXT_WREN = 16'h5745;
	localparam logic [15:0] TXT_BIT_LVL = 16'h5242;
	localparam logic [15:0] TXT_POS_LVL = 16'h5250;
	localparam logic [23:0] TXT_CONT_MODE = 24'h52434d;
	localparam logic [23:0] TXT_CONT_TMR = 24'h524354;
	localparam logic [23:0] TXT_IN_ADDR = 24'h524941;
	localparam logic [23:0] TXT_USER_NOTE = 24'h524944;
	localparam logic [23:0] TXT_BOOT_OUT = 24'h524956;
	localparam logic [23:0] TXT_CONFIG = 24'h525355;
	localparam logic [23:0] TXT_DOG_TIME = 24'h525754;
	localparam logic [23:0] TXT_DIR_BIT = 24'h524142;
	localparam logic [23:0] TXT_DIR_POS = 24'h524150;
	localparam logic [23:0] TXT_IN_BIT = 24'h524942;
	localparam logic [23:0] TXT_IN_POS = 24'h524950;
	localparam logic [119:0] MSG_VALUE = "VALUE ERROR";
	localparam logic [119:0] MSG_WP = "WRITE PROTECTED";
	localparam logic [119:0] MSG_CMD = "COMMAND ERROR";
	localparam logic [119:0] MSG_SYN = "SYNTAX ERROR";

endpackage

// [iocmd_props.sv]
`timescale 1ns/100ps
module iocmd_props (
	input wire logic CLK,
	input wire logic SRST,
	input wire iocmd_pkg::apb_req_t APB_REQ,
	input wire iocmd_pkg::apb_rsp_t APB_RSP,
	input wire logic RX_READY,
	input wire logic [7:0] TX_DATA,
	input wire logic TX_VALID,
	input wire logic TX_READY,
	input wire logic CPU_KICK,
	input wire logic DOG_KICK
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (SRST);
	// ----------------------------------------------------------------
	// serial side
	// ----------------------------------------------------------------
	poll_kick_a: assert property (
		DOG_KICK |-> !RX_READY ##1 !DOG_KICK) else $error("poll kick bad");
	reset_kick_a: assert property (
		CPU_KICK |-> !RX_READY ##1 !CPU_KICK) else $error("reset kick bad");
	reply_hold_a: assert property (
		TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
		else $error("reply char dropped");
	reply_start_a: assert property (
		$fell(RX_READY) |-> ##2 TX_VALID) else $error("reply late");
	half_duplex_a: assert property (
		TX_VALID |-> !RX_READY) else $error("rx open while replying");
	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	ready_pulse_a: assert property (
		APB_RSP.pready |=> !APB_RSP.pready) else $error("pready too long");
	ready_time_a: assert property (
		APB_REQ.psel && $rose(APB_REQ.penable) |=> APB_RSP.pready)
		else $error("pready late");
	slverr_zero_a: assert property (
		APB_RSP.pslverr |-> APB_RSP.pready && APB_RSP.prdata == 32'h0)
		else $error("error response malformed");
	cover property (DOG_KICK);
	cover property (CPU_KICK);
	cover property (APB_RSP.pslverr);
endmodule

// [iocmd_host.sv]
`timescale 1ns/100ps
module iocmd_host (
	input wire logic clk,
	input wire logic rx_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic tx_ready
);
	bit slow = 1'b0;
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b1;
	end
	// sends a frame plus CR, then gathers the reply until rx reopens
	task automatic cmd(input string s, output string r);
		int n;
		bit low;
		r = "";
		low = 1'b0;
		@(posedge clk);
		for (int i = 0; i <= s.len(); i++) begin
			rx_data <= (i == s.len()) ? iocmd_pkg::CH_CR : s[i];
			rx_valid <= 1'b1;
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (!rx_ready && n < 64);
		end
		// released line shows the inverse, never a stale copy
		rx_valid <= 1'b0;
		rx_data <= ~iocmd_pkg::CH_CR;
		n = 0;
		while (n < 400 && !(low && rx_ready)) begin
			tx_ready <= slow ? ~tx_ready : 1'b1;
			@(posedge clk);
			n++;
			if (tx_valid && tx_ready)
				r = $sformatf("%s%c", r, tx_data);
			if (!rx_ready)
				low = 1'b1;
		end
	endtask
endmodule

// [test_io_module_readback_cmds.sv]
`timescale 1ns/100ps
module test_io_module_readback_cmds;
	logic clk, srst, evt, cpu_kick, dog_kick, rx_ready, rx_valid;
	logic tx_valid, tx_ready;
	logic [7:0] rx_data, tx_data;
	logic [63:0] line_in;
	iocmd_pkg::apb_req_t req;
	iocmd_pkg::apb_rsp_t rsp;
	int n_mismatch = 0, check_count = 0, dogs = 0, kicks = 0;
	logic [31:0] q;
	string r, m = "CDEIT";
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		dogs += (dog_kick === 1'b1);
		kicks += (cpu_kick === 1'b1);
	end
	iocmd_core iocmd_core_inst (.CLK(clk), .SRST(srst), .APB_REQ(req),
		.APB_RSP(rsp), .RX_DATA(rx_data), .RX_VALID(rx_valid),
		.RX_READY(rx_ready), .TX_DATA(tx_data), .TX_VALID(tx_valid),
		.TX_READY(tx_ready), .LINE_IN(line_in), .EVENT(evt),
		.CPU_KICK(cpu_kick), .DOG_KICK(dog_kick));
	iocmd_host iocmd_host_inst (.clk(clk), .rx_ready(rx_ready),
		.tx_data(tx_data), .tx_valid(tx_valid), .rx_data(rx_data),
		.rx_valid(rx_valid), .tx_ready(tx_ready));
	task automatic check(input string got, exp);
		check_count++;
		if (got != exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t got %s want %s", $time, got, exp);
		end
	endtask
	task automatic ask(input string s, exp);
		iocmd_host_inst.cmd(s, r);
		check(r, exp);
	endtask
	// one apb transfer, q and err string taken at the pready edge
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d, output string e);
		@(posedge clk);
		req <= '{a, w, 1'b1, 1'b0, d};
		@(posedge clk);
		req.penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (!rsp.pready);
		q = rsp.prdata;
		e = $sformatf("%h%b", q, rsp.pslverr);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic events(input int n);
		evt <= 1'b1;
		repeat (n) @(posedge clk);
		evt <= 1'b0;
	endtask
	task automatic test_done;
		if (n_mismatch == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		srst = 1'b1;
		req = '0;
		line_in = '0;
		evt = 1'b0;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		apb(iocmd_pkg::OFS_CONFIG, 0, 0, r);
		check(r, "310701020");
		apb(iocmd_pkg::OFS_TALLY, 0, 0, r);
		check(r, "000000000");
		apb(8'h80, 0, 0, r);
		check(r, "000000001");
		ask("$1RD", "*+99999.99");
		ask("$1", "*+99999.99");
		check($sformatf("%0d", dogs), "2");
		apb(iocmd_pkg::OFS_DIR_LO, 1, 32'h0000_40ff, r);
		apb(iocmd_pkg::OFS_DIR_HI, 1, 32'hffff_ffff, r);
		ask("$1RA", "*40FF");
		ask("$1RAB0E", "*O");
		ask("$1RAP14", "*O");
		ask("$1RAP15", "*I");
		line_in <= 64'h0000_0000_0000_8000;
		apb(iocmd_pkg::OFS_LINE_LO, 0, 0, r);
		check(r, "000080000");
		ask("$1RB0F", "*1");
		ask("$1RP15", "*1");
		ask("$1RIB0E", "*0");
		ask("$1RIP15", "*1");
		ask("$1RB10", "?1 VALUE ERROR");
		ask("$1RP16", "?1 VALUE ERROR");
		ask("$1XY", "?1 COMMAND ERROR");
		ask("$1AAAAAAAAAAAAAAAAAAAAAAAA", "?1 SYNTAX ERROR");
		for (int i = 0; i < 5; i++) begin
			apb(iocmd_pkg::OFS_MODE, 1, i, r);
			ask("$1RCM", {"*", m.substr(i, i)});
		end
		ask("$1RCT", "*+00005.00");
		apb(iocmd_pkg::OFS_CONT_TMR, 1, 32'h8000_0250, r);
		ask("$1RCT", "*-00002.50");
		ask("$1RIA", "*41");
		ask("$1RWT", "*+99999.99");
		apb(iocmd_pkg::OFS_DOG_TIME, 1, 32'h0000_1000, r);
		ask("$1RWT", "*+00010.00");
		apb(iocmd_pkg::OFS_NOTE0, 1, 32'h4c49_4f42, r);
		ask("$1RID", "*BOIL");
		apb(iocmd_pkg::OFS_BOOT_LO, 1, 32'h0000_0f0f, r);
		ask("$1RIV", "*0F0F");
		iocmd_host_inst.slow = 1'b1;
		ask("$1RSU", "*31070102");
		iocmd_host_inst.slow = 1'b0;
		ask("$1RS", "*31070102");
		ask("#1RS00", "*1RS310701028E");
		events(107);
		ask("$1RE", "*0000107");
		ask("$1EC", "*0000107");
		ask("$1RE", "*0000000");
		events(3);
		ask("$1CE", "*");
		ask("$1RE", "*0000000");
		events(5);
		ask("$1RR", "?1 WRITE PROTECTED");
		ask("$1WE", "*");
		apb(iocmd_pkg::OFS_STATUS, 0, 0, r);
		check(r, "000000010");
		ask("$1RB10", "?1 VALUE ERROR");
		ask("$1RR", "*");
		check($sformatf("%0d", kicks), "1");
		ask("$1RE", "*0000005");
		check($sformatf("%0d", dogs), "2");
		test_done();
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		test_done();
	end
endmodule
bind iocmd_core iocmd_props iocmd_props_inst (.CLK(CLK), .SRST(SRST),
	.APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .RX_READY(RX_READY),
	.TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
	.CPU_KICK(CPU_KICK), .DOG_KICK(DOG_KICK));
